// ### design/pposm_map.vh
// Register map and field constants of the port pin override mux.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef PPOSM_MAP_VH
`define PPOSM_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PPOSM_OFS_OUTPUT 8'h00
`define PPOSM_OFS_DIR 8'h04
`define PPOSM_OFS_INPUT 8'h08
`define PPOSM_OFS_MCU_CTRL 8'h0C
`define PPOSM_OFS_EXT_IRQ 8'h10
`define PPOSM_ADDR_W 8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPOSM_MCU_PUD_BIT 0
`define PPOSM_IRQ_EN_BIT 0
`define PPOSM_IRQ_SENSE_LO 1
`define PPOSM_IRQ_SENSE_HI 2
`define PPOSM_IRQ_FLAG_BIT 4

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define PPOSM_RST_OUTPUT 6'h00
`define PPOSM_RST_DIR 6'h00
`define PPOSM_RST_PUD 1'h0
`define PPOSM_RST_SENSE 2'h0
`define PPOSM_SENSE_LEVEL 2'h0
`define PPOSM_SENSE_ANY 2'h1
`define PPOSM_SENSE_FALL 2'h2
`define PPOSM_SENSE_RISE 2'h3
`define PPOSM_PULLUP_ON_CODE 3'h2
`define PPOSM_RESP_OKAY 2'h0
`define PPOSM_RESP_SLVERR 2'h2

`endif

// ### design/pposm_pin_cell.v
// One pin of the port: pad control, input clamp and input synchroniser.
// Assumes override enables already masked for absent functions.
`timescale 1ns/100ps
`default_nettype none
`include "pposm_map.vh"

module pposm_pin_cell (
  input wire i_clock,
  input wire i_nrst,
  input wire i_dir_bit,
  input wire i_out_bit,
  input wire i_global_pullup_disable,
  input wire i_clamp,
  input wire i_pullup_override_en,
  input wire i_pullup_override_val,
  input wire i_dir_override_en,
  input wire i_dir_override_val,
  input wire i_value_override_en,
  input wire i_value_override_val,
  input wire i_input_en_override_en,
  input wire i_input_en_override_val,
  input wire i_pad_in,
  output wire o_pad_out,
  output wire o_pad_oe,
  output wire o_pullup_en,
  output wire o_alt_logic_input,
  output wire o_sync_in
);

  wire plain_pullup;
  wire input_en;
  reg sync1_ff;
  reg sync2_ff;

  // ----------------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------------
  assign plain_pullup = ({i_dir_bit, i_out_bit, i_global_pullup_disable}
                         == `PPOSM_PULLUP_ON_CODE); // [RULE4] [RULE20]
  // Pull-up held off in reset so the pad floats until configured
  assign o_pullup_en = i_nrst & (i_pullup_override_en ? i_pullup_override_val
                                 : plain_pullup); // [RULE4] [RULE5] [RULE17]
  assign o_pad_oe = i_dir_override_en ? i_dir_override_val
                    : i_dir_bit; // [RULE6] [RULE7] [RULE19]
  assign o_pad_out = i_value_override_en ? i_value_override_val
                     : i_out_bit; // [RULE8] [RULE9]

  // ----------------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------------
  assign input_en = i_input_en_override_en ? i_input_en_override_val
                    : ~i_clamp; // [RULE11] [RULE12] [RULE1]
  // Clamped to ground ahead of the trigger; unsynchronised tap
  assign o_alt_logic_input = i_pad_in & input_en; // [RULE1] [RULE13]

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= o_alt_logic_input;
      sync2_ff <= sync1_ff;
    end
  end

  assign o_sync_in = sync2_ff;

endmodule

`default_nettype wire

// ### design/pposm_port.v
// Port pin override mux: six pins, AXI4-Lite register slave.
// Assumes override signals come from peripherals on i_clock; pads
// are resolved outside from pad_out/pad_oe/pullup_en.
//
// Operation
// [RULE1] Deep sleep clamps every pin's digital input to ground before the trigger.
// [RULE2] Clamp skips the external interrupt pin while its interrupt is enabled.
// [RULE3] Leaving clamp with edge-sensed ext pin high and irq disabled sets flag.
// [RULE4] Pull-up follows override value if enabled, else on when dir,out,pud=010.
// [RULE5] Enabled pull-up override forces pull-up to its value regardless of bits.
// [RULE6] Driver enable comes from direction override value, else direction bit.
// [RULE7] Enabled direction override turns driver on or off, ignoring direction bit.
// [RULE8] Driven level comes from value override if enabled, else output bit.
// [RULE9] Enabled value override sets the port value regardless of output bit.
// [RULE10] Toggle override enable inverts the pin's output register bit.
// [RULE11] Input enable follows override value if enabled, else normal/clamp state.
// [RULE12] Enabled input override decides input enable whether running or asleep.
// [RULE13] Peripherals synchronise the raw alternate input unless used as a clock.
// [RULE14] Alternate analog path connects straight to the pad, unbuffered.
// [RULE15] Clock, clamp and pull-up disable shared; overrides separate per pin.
// [RULE16] Peripherals generate each pin's override enables and values themselves.
// [RULE17] Pull-ups enabled by output bit are switched off during reset.
// [RULE18] Each pin is pin-change source with index equal to its bit number.
// [RULE19] Direction bit one makes the pin an output, zero an input.
// [RULE20] Global pull-up disable turns off pull-ups on every pin.
// [RULE21] Writing one to input register bit inverts that pin's output bit.
// [RULE22] Missing override enables are tied low so port bits keep control.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pposm_map.vh"

module pposm_port #(
  parameter PINS = 6,
  parameter EXT_IRQ_PIN = 2,
  parameter [5:0] HAS_PULLUP_OVR = 6'h3F,
  parameter [5:0] HAS_DIR_OVR = 6'h3F,
  parameter [5:0] HAS_VALUE_OVR = 6'h3F,
  parameter [5:0] HAS_TOGGLE_OVR = 6'h3F,
  parameter [5:0] HAS_INPUT_EN_OVR = 6'h3F
) (
  input wire i_clock,
  input wire i_nrst,
  // AXI4-Lite slave
  input wire i_awvalid,
  output wire o_awready,
  input wire [7:0] i_awaddr,
  input wire [2:0] i_awprot,
  input wire i_wvalid,
  output wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  output wire o_bvalid,
  input wire i_bready,
  output wire [1:0] o_bresp,
  input wire i_arvalid,
  output wire o_arready,
  input wire [7:0] i_araddr,
  input wire [2:0] i_arprot,
  output wire o_rvalid,
  input wire i_rready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  // Sleep controller
  input wire i_deep_sleep,
  // Peripheral overrides, one bit per pin
  input wire [5:0] i_pullup_override_en,
  input wire [5:0] i_pullup_override_val,
  input wire [5:0] i_dir_override_en,
  input wire [5:0] i_dir_override_val,
  input wire [5:0] i_value_override_en,
  input wire [5:0] i_value_override_val,
  input wire [5:0] i_toggle_override_en,
  input wire [5:0] i_input_en_override_en,
  input wire [5:0] i_input_en_override_val,
  output wire [5:0] o_alt_logic_input,
  output wire [5:0] o_alt_analog_pad,
  // Pads
  input wire [5:0] i_pad_in,
  output wire [5:0] o_pad_out,
  output wire [5:0] o_pad_oe,
  output wire [5:0] o_pullup_en,
  // Events
  output wire [5:0] o_pin_change,
  output wire o_ext_irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg [5:0] out_ff;
  reg [5:0] nxt_out;
  reg [5:0] dir_ff;
  reg pud_ff;
  reg irq_en_ff;
  reg [1:0] sense_ff;
  reg irq_flag_ff;
  reg nxt_irq_flag;
  reg [5:0] prev_in_ff;
  reg [5:0] pin_change_vec_ff;
  reg sleep_prev_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  wire [5:0] sync_in;
  wire [5:0] clamp;
  wire wr_fire;
  wire rd_fire;
  wire wr_lane0;
  wire ext_pin;
  wire ext_prev;
  wire edge_event;
  wire wake_event;
  wire [5:0] toggle_en;
  wire [5:0] pin_write;

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  // Address and data are taken together; simpler than buffering either
  assign wr_fire = i_awvalid & i_wvalid & ~bvalid_ff;
  assign o_awready = wr_fire;
  assign o_wready = wr_fire;
  assign wr_lane0 = wr_fire & i_wstrb[0];

  always @* begin
    case (i_awaddr)
      `PPOSM_OFS_OUTPUT: wr_hit = 1'b1;
      `PPOSM_OFS_DIR: wr_hit = 1'b1;
      `PPOSM_OFS_INPUT: wr_hit = 1'b1;
      `PPOSM_OFS_MCU_CTRL: wr_hit = 1'b1;
      `PPOSM_OFS_EXT_IRQ: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `PPOSM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? `PPOSM_RESP_OKAY : `PPOSM_RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;

  // ----------------------------------------------------------------------
  // Port bits
  // ----------------------------------------------------------------------
  assign toggle_en = i_toggle_override_en & HAS_TOGGLE_OVR; // [RULE22]
  assign pin_write = (wr_lane0 && i_awaddr == `PPOSM_OFS_INPUT) ?
                     i_wdata[5:0] : 6'h00;

  always @* begin
    nxt_out = out_ff;
    if (wr_lane0 && i_awaddr == `PPOSM_OFS_OUTPUT) begin
      nxt_out = i_wdata[5:0];
    end
    // Toggles act on top of a same-cycle write
    nxt_out = nxt_out ^ pin_write ^ toggle_en; // [RULE21] [RULE10]
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      out_ff <= `PPOSM_RST_OUTPUT;
      dir_ff <= `PPOSM_RST_DIR;
      pud_ff <= `PPOSM_RST_PUD;
      irq_en_ff <= 1'b0;
      sense_ff <= `PPOSM_RST_SENSE;
    end else begin
      out_ff <= nxt_out;
      if (wr_lane0 && i_awaddr == `PPOSM_OFS_DIR) begin
        dir_ff <= i_wdata[5:0];
      end
      if (wr_lane0 && i_awaddr == `PPOSM_OFS_MCU_CTRL) begin
        pud_ff <= i_wdata[`PPOSM_MCU_PUD_BIT];
      end
      if (wr_lane0 && i_awaddr == `PPOSM_OFS_EXT_IRQ) begin
        irq_en_ff <= i_wdata[`PPOSM_IRQ_EN_BIT];
        sense_ff <= i_wdata[`PPOSM_IRQ_SENSE_HI:`PPOSM_IRQ_SENSE_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
      // Shared sleep clamp, lifted only for an enabled ext interrupt pin
      assign clamp[gi] = i_deep_sleep &
                         ~((gi == EXT_IRQ_PIN) && irq_en_ff); // [RULE2] [RULE15]
      // Analog path is the pad itself
      assign o_alt_analog_pad[gi] = i_pad_in[gi]; // [RULE14]
      pposm_pin_cell u_cell (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_dir_bit(dir_ff[gi]),
        .i_out_bit(out_ff[gi]),
        .i_global_pullup_disable(pud_ff),
        .i_clamp(clamp[gi]),
        .i_pullup_override_en(i_pullup_override_en[gi] & HAS_PULLUP_OVR[gi]),
        .i_pullup_override_val(i_pullup_override_val[gi]),
        .i_dir_override_en(i_dir_override_en[gi] & HAS_DIR_OVR[gi]),
        .i_dir_override_val(i_dir_override_val[gi]),
        .i_value_override_en(i_value_override_en[gi] & HAS_VALUE_OVR[gi]),
        .i_value_override_val(i_value_override_val[gi]),
        .i_input_en_override_en(i_input_en_override_en[gi] &
                                HAS_INPUT_EN_OVR[gi]),
        .i_input_en_override_val(i_input_en_override_val[gi]),
        .i_pad_in(i_pad_in[gi]),
        .o_pad_out(o_pad_out[gi]),
        .o_pad_oe(o_pad_oe[gi]),
        .o_pullup_en(o_pullup_en[gi]),
        .o_alt_logic_input(o_alt_logic_input[gi]),
        .o_sync_in(sync_in[gi])
      ); // [RULE22] [RULE15]
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pin change and external interrupt
  // ----------------------------------------------------------------------
  assign ext_pin = sync_in[EXT_IRQ_PIN];
  assign ext_prev = prev_in_ff[EXT_IRQ_PIN];
  assign edge_event = (sense_ff == `PPOSM_SENSE_ANY && ext_pin != ext_prev) ||
                      (sense_ff == `PPOSM_SENSE_FALL && !ext_pin && ext_prev) ||
                      (sense_ff == `PPOSM_SENSE_RISE && ext_pin && !ext_prev);
  // Clamp release looks like a change on a high pin
  assign wake_event = sleep_prev_ff & ~i_deep_sleep & ~irq_en_ff &
                      (sense_ff != `PPOSM_SENSE_LEVEL) & i_pad_in[EXT_IRQ_PIN]; // [RULE3]

  always @* begin
    nxt_irq_flag = irq_flag_ff;
    if (wr_lane0 && i_awaddr == `PPOSM_OFS_EXT_IRQ &&
        i_wdata[`PPOSM_IRQ_FLAG_BIT]) begin
      nxt_irq_flag = 1'b0;
    end
    // Set beats a same-cycle clear
    if (edge_event || wake_event) begin
      nxt_irq_flag = 1'b1; // [RULE3]
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_in_ff <= 6'h00;
      pin_change_vec_ff <= 6'h00;
      sleep_prev_ff <= 1'b0;
      irq_flag_ff <= 1'b0;
    end else begin
      prev_in_ff <= sync_in;
      pin_change_vec_ff <= sync_in ^ prev_in_ff; // [RULE18]
      sleep_prev_ff <= i_deep_sleep;
      irq_flag_ff <= nxt_irq_flag;
    end
  end

  assign o_pin_change = pin_change_vec_ff; // [RULE18]
  assign o_ext_irq = irq_flag_ff & irq_en_ff;

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  assign o_arready = ~rvalid_ff;
  assign rd_fire = i_arvalid & ~rvalid_ff;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (i_araddr)
      `PPOSM_OFS_OUTPUT: rd_word[5:0] = out_ff;
      `PPOSM_OFS_DIR: rd_word[5:0] = dir_ff;
      `PPOSM_OFS_INPUT: rd_word[5:0] = sync_in;
      `PPOSM_OFS_MCU_CTRL: rd_word[`PPOSM_MCU_PUD_BIT] = pud_ff;
      `PPOSM_OFS_EXT_IRQ: begin
        rd_word[`PPOSM_IRQ_EN_BIT] = irq_en_ff;
        rd_word[`PPOSM_IRQ_SENSE_HI:`PPOSM_IRQ_SENSE_LO] = sense_ff;
        rd_word[`PPOSM_IRQ_FLAG_BIT] = irq_flag_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `PPOSM_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? `PPOSM_RESP_OKAY : `PPOSM_RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

endmodule

`default_nettype wire

// ### verif/pposm_periph_model.sv
// Peripheral side: override requests for six pins, and an input sync.
// Assumes the bench loads one packed request word per change.
`timescale 1ns/100ps
`default_nettype none
module pposm_periph_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic [53:0] i_req,
  input wire logic [5:0] i_alt_logic_input,
  output logic [53:0] o_ovr,
  output logic [5:0] o_sync
);
  logic [5:0] meta_ff;
  // Toggle field lasts one cycle, so each load toggles once
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst) begin
      o_ovr <= 54'h0;
      meta_ff <= 6'h00;
      o_sync <= 6'h00;
    end else begin
      o_ovr <= i_load ? i_req : {6'h00, o_ovr[47:0]};
      meta_ff <= i_alt_logic_input;
      o_sync <= meta_ff;
    end
endmodule
`default_nettype wire

// ### verif/pposm_port_checker.sv
// Checker: pad control and input path relations of the pin mux.
// Assumes it is bound to pposm_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pposm_port_checker (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_deep_sleep,
  input wire logic [5:0] i_pullup_override_en,
  input wire logic [5:0] i_pullup_override_val,
  input wire logic [5:0] i_dir_override_en,
  input wire logic [5:0] i_dir_override_val,
  input wire logic [5:0] i_value_override_en,
  input wire logic [5:0] i_value_override_val,
  input wire logic [5:0] i_input_en_override_en,
  input wire logic [5:0] i_input_en_override_val,
  input wire logic [5:0] i_pad_in,
  input wire logic [5:0] o_alt_logic_input,
  input wire logic [5:0] o_alt_analog_pad,
  input wire logic [5:0] o_pad_out,
  input wire logic [5:0] o_pad_oe,
  input wire logic [5:0] o_pullup_en,
  input wire logic [5:0] o_pin_change
);
  // Sync history is meaningless until five edges after release
  logic [2:0] up_ff;
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst) up_ff <= 3'h0;
    else if (up_ff != 3'h5) up_ff <= up_ff + 3'h1;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  property p_pu_ovr;
    (o_pullup_en & i_pullup_override_en) == (i_pullup_override_val & i_pullup_override_en);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override lost");
  property p_dir_ovr;
    |i_dir_override_en |-> (o_pad_oe & i_dir_override_en) == (i_dir_override_val & i_dir_override_en);
  endproperty
  a_dir_ovr: assert property (p_dir_ovr) else $error("driver override lost");
  property p_val_ovr;
    |i_value_override_en |-> (o_pad_out & i_value_override_en) == (i_value_override_val & i_value_override_en);
  endproperty
  a_val_ovr: assert property (p_val_ovr) else $error("value override lost");
  property p_pu_rst;
    disable iff (1'b0) !i_nrst |-> o_pullup_en == 6'h00;
  endproperty
  a_pu_rst: assert property (p_pu_rst) else $error("pull-up on in reset");
  property p_analog;
    o_alt_analog_pad == i_pad_in;
  endproperty
  a_analog: assert property (p_analog) else $error("analog path differs");
  property p_clamp;
    i_deep_sleep |-> (o_alt_logic_input & ~i_input_en_override_en & 6'h3B) == 6'h00;
  endproperty
  a_clamp: assert property (p_clamp) else $error("input not clamped");
  property p_ien_ovr;
    (o_alt_logic_input & i_input_en_override_en) == (i_pad_in & i_input_en_override_en & i_input_en_override_val);
  endproperty
  a_ien_ovr: assert property (p_ien_ovr) else $error("input override lost");
  property p_pchg;
    up_ff == 3'h5 |-> o_pin_change == ($past(o_alt_logic_input, 3) ^ $past(o_alt_logic_input, 4));
  endproperty
  a_pchg: assert property (p_pchg) else $error("pin change pulse wrong");
endmodule
bind pposm_port pposm_port_checker u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_deep_sleep(i_deep_sleep), .i_pullup_override_en(i_pullup_override_en),
  .i_pullup_override_val(i_pullup_override_val), .i_dir_override_en(i_dir_override_en),
  .i_dir_override_val(i_dir_override_val), .i_value_override_en(i_value_override_en),
  .i_value_override_val(i_value_override_val), .i_pad_in(i_pad_in),
  .i_input_en_override_en(i_input_en_override_en), .o_pad_out(o_pad_out),
  .i_input_en_override_val(i_input_en_override_val), .o_pad_oe(o_pad_oe),
  .o_alt_logic_input(o_alt_logic_input), .o_alt_analog_pad(o_alt_analog_pad),
  .o_pullup_en(o_pullup_en), .o_pin_change(o_pin_change));
`default_nettype wire

// ### verif/pposm_port_tb.sv
// Bench for pposm_port: register traffic, override mixes, sleep clamp.
// Assumes the bound checker; the peripheral model drives all overrides.
`timescale 1ns/100ps
`default_nettype none
module pposm_port_tb;
  logic i_clock, i_nrst, awvalid, wvalid, bready, arvalid, rready, deep, load, p;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [53:0] req, r;
  logic [5:0] ext, d, o;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] alt, pout, oe, pue;
  wire [53:0] ovr;
  wire [5:0] pad = (oe & pout) | (~oe & ext);
  integer errors, checks, seed, i;
  pposm_periph_model u_per (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(load),
    .i_req(req), .i_alt_logic_input(alt), .o_ovr(ovr), .o_sync());
  pposm_port dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .i_arprot(3'h0), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_deep_sleep(deep), .i_pullup_override_en(ovr[5:0]),
    .i_pullup_override_val(ovr[11:6]), .i_dir_override_en(ovr[17:12]),
    .i_dir_override_val(ovr[23:18]), .i_value_override_en(ovr[29:24]),
    .i_value_override_val(ovr[35:30]), .i_input_en_override_en(ovr[41:36]),
    .i_input_en_override_val(ovr[47:42]), .i_toggle_override_en(ovr[53:48]),
    .o_alt_logic_input(alt), .o_alt_analog_pad(), .i_pad_in(pad), .o_pad_out(pout),
    .o_pad_oe(oe), .o_pullup_en(pue), .o_pin_change(), .o_ext_irq(irq));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input integer n);
    if (n >= 50) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] v, input [1:0] er);
    integer n;
    @(posedge i_clock);
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel released at its own take edge
    do begin
      @(posedge i_clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 50);
    do @(posedge i_clock) n++; while (!bvalid && n < 50);
    bready <= 1'b0;
    tmo(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    integer n;
    @(posedge i_clock);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_clock) n++; while (!arready && n < 50);
    arvalid <= 1'b0;
    do @(posedge i_clock) n++; while (!rvalid && n < 50);
    rready <= 1'b0;
    tmo(n);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // Pad controls {oe, out, pull-up} from port bits and overrides
  function automatic [31:0] exp_pad(input [5:0] dd, oo, input pp, input [53:0] rr);
    exp_pad = {14'h0, (rr[17:12] & rr[23:18]) | (~rr[17:12] & dd),
      (rr[29:24] & rr[35:30]) | (~rr[29:24] & oo),
      (rr[5:0] & rr[11:6]) | (~rr[5:0] & ~dd & oo & {6{~pp}})};
  endfunction
  task automatic setcfg(input [53:0] rr);
    wr(8'h04, {26'h0, d}, 2'h0);
    wr(8'h00, {26'h0, o}, 2'h0);
    wr(8'h0C, {31'h0, p}, 2'h0);
    @(posedge i_clock);
    req <= rr;
    load <= 1'b1;
    @(posedge i_clock);
    load <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  initial begin
    {i_nrst, awvalid, wvalid, bready, arvalid, rready, deep, load} = 8'h00;
    {awaddr, araddr, wdata, req, r, ext, d, o, p} = '0;
    errors = 0;
    checks = 0;
    seed = 32'h216E;
    repeat (12) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    wr(8'h20, 32'h1, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    $display("test regs done");
    for (i = 0; i < 26; i++) begin
      d = 6'($random(seed));
      o = 6'($random(seed));
      p = 1'($random(seed));
      ext <= 6'($random(seed));
      r = 54'({$random(seed), $random(seed)});
      if (i == 24) r = '1;
      if (i == 25) r = '0;
      setcfg(r & 54'hFFFFFFFFF);
      chk({14'h0, oe, pout, pue}, exp_pad(d, o, p, req));
      rd(8'h08, {26'h0, pad}, 2'h0);
    end
    $display("test mix done");
    d = 6'h3F;
    o = 6'h0F;
    setcfg(54'h21000000000000);
    rd(8'h00, 32'h2E, 2'h0);
    wr(8'h08, 32'h3, 2'h0);
    rd(8'h00, 32'h2D, 2'h0);
    chk({26'h0, pout}, 32'h2D);
    $display("test toggle done");
    d = 6'h00;
    o = 6'h00;
    setcfg(54'h0);
    ext <= 6'h3F;
    deep <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({26'h0, alt}, 32'h0);
    wr(8'h10, 32'h1, 2'h0);
    repeat (2) @(posedge i_clock);
    chk({26'h0, alt}, 32'h4);
    setcfg(54'h57F000000000);
    chk({26'h0, alt}, 32'h15);
    setcfg(54'h03F000000000);
    chk({26'h0, alt}, 32'h0);
    wr(8'h10, 32'h6, 2'h0);
    setcfg(54'h0);
    rd(8'h10, 32'h6, 2'h0);
    deep <= 1'b0;
    repeat (6) @(posedge i_clock);
    rd(8'h10, 32'h16, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h10, 32'h16, 2'h0);
    rd(8'h10, 32'h6, 2'h0);
    chk({26'h0, alt}, 32'h3F);
    // Any-change then falling sense, enabled, on the interrupt pin
    wr(8'h10, 32'h13, 2'h0);
    ext <= 6'h3B;
    repeat (4) @(posedge i_clock);
    chk({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h15, 2'h0);
    rd(8'h10, 32'h5, 2'h0);
    ext <= 6'h3F;
    repeat (4) @(posedge i_clock);
    chk({31'h0, irq}, 32'h0);
    ext <= 6'h3B;
    repeat (4) @(posedge i_clock);
    chk({31'h0, irq}, 32'h1);
    $display("test sleep done");
    complete_run();
  end
endmodule
`default_nettype wire
